// ---- common/ddc_consts.svh ----
// Purpose: Named offsets, field positions and counts of the channel control
// Assumes: Included by bare name from the package only
// Notes:   Bit numbers are vector indices, bit 15 being the channel's bit 0
`ifndef DDC_CONSTS_SVH
`define DDC_CONSTS_SVH

// ----------------------------------------------------------------------
// Command/address word fields
// ----------------------------------------------------------------------
`define DDC_CA_RELEASE    15
`define DDC_CA_SECTOR     14
`define DDC_CA_DIFF       13
`define DDC_CA_CLEAR      12
`define DDC_CA_UNIT       8
`define DDC_CA_LOGIC_HI   11
`define DDC_CA_LOGIC_LO   9
`define DDC_CA_PAGE_HI    11
`define DDC_CA_PAGE_LO    8
`define DDC_CA_WRITE      7
`define DDC_CA_BUS_HI     7
`define DDC_CA_HDR_HI     5

// ----------------------------------------------------------------------
// Strobe/connect word fields
// ----------------------------------------------------------------------
`define DDC_SC_BEGIN      7
`define DDC_SC_CLREOP     6
`define DDC_SC_LOADADR    5
`define DDC_SC_CTRLSEL    4
`define DDC_SC_FUNC       3
`define DDC_SC_CONN_HI    2

// ----------------------------------------------------------------------
// Interface and drive status word fields
// ----------------------------------------------------------------------
`define DDC_IS_FULL       6
`define DDC_IS_RDERR      5
`define DDC_IS_TAGERR     4
`define DDC_IS_EOP        3
`define DDC_DS_BUSY       6
`define DDC_DS_READY      5
`define DDC_DS_SEEKERR    4
`define DDC_DS_ONCYL      3
`define DDC_DS_UNSAFE     2
`define DDC_DS_XFERERR    1
`define DDC_DS_NOTFIN     0

// ----------------------------------------------------------------------
// Sizes, resets and counts
// ----------------------------------------------------------------------
`define DDC_PAGE_WORDS    2048
`define DDC_HDR_WORDS     30
`define DDC_CRC_POLY      16'h8005
`define DDC_CRC_INIT      16'h0000
`define DDC_WORD_ZERO     16'h0000
`define DDC_BANK_BACK     3'h4
`define DDC_CNT_LIMIT     4096

`endif

// ---- common/ddc_pkg.sv ----
// Purpose: Types shared by the disk channel control modules
// Assumes: Constants come from the consts header
// Notes:   Holds the transfer sequencer state type
package ddc_pkg;
`include "ddc_consts.svh"

   // Transfer sequencer states
   typedef enum logic [2:0] {
      XS_IDLE,
      XS_TAGW,
      XS_TAGC,
      XS_HDR,
      XS_PAGE,
      XS_BCC
   } ddc_xfer_t;

   // Addressing mode from the bank switch
   typedef enum logic [1:0] {
      BM_FULL,
      BM_EVEN,
      BM_ODD
   } ddc_bank_t;
endpackage

// ---- hdl/ddc_sync.sv ----
// Purpose: Two-stage synchroniser for a vector of asynchronous levels
// Assumes: Bits are independent levels, not a coherent word
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module ddc_sync #(
   parameter int W = 16
) (
   input  wire logic         clock,
   input  wire logic         rstn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta_r;

   // ----------------------------------------------------------------------
   // Two flip-flop chain
   // ----------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rstn) begin
         meta_r <= '0;
         dout   <= '0;
      end else begin
         meta_r <= din;
         dout   <= meta_r;
      end
   end
endmodule

// ---- hdl/ddc_crc.sv ----
// Purpose: Word-serial 16-bit check-code generator
// Assumes: One data word per enable, restarted by init
// Notes:   Polynomial is a parameter; result is registered
`timescale 1ns/1ps
module ddc_crc
   import ddc_pkg::*;
#(
   parameter logic [15:0] POLY = `DDC_CRC_POLY
) (
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic        init,
   input  wire logic        en,
   input  wire logic [15:0] data,
   output logic      [15:0] crc
);
   logic [15:0] crcNxt;

   // Shift sixteen data bits through the divider, msb first
   always_comb begin
      crcNxt = crc;
      for (int i = 15; i >= 0; i--) begin
         if (crcNxt[15] ^ data[i]) begin
            crcNxt = {crcNxt[14:0], 1'b0} ^ POLY;
         end else begin
            crcNxt = {crcNxt[14:0], 1'b0};
         end
      end
   end

   // ----------------------------------------------------------------------
   // Accumulator
   // ----------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rstn || init) begin
         crc <= `DDC_CRC_INIT;
      end else if (en) begin
         crc <= crcNxt;
      end
   end
endmodule

// ---- hdl/ddc_channel_ctrl.sv ----
// Purpose: Channel control and status of the multi_disk_drive interface
// Assumes: Channel words and drive lines are asynchronous to clock
// Notes:   Disk and buffer_memory data paths are outside; words strobe in
`timescale 1ns/1ps
// What this block does
// - Tag check error when read check word differs from generated one
// - End-of-page status once a full page has moved
// - On read error show complemented bank number being accessed
// - Transfer error on read error, tag check error or tag mismatch
// - Not-finished bit stays set while a transfer is in progress
// - Command bits act under function; address bits under load strobe
// - Write-tags makes timing write gap, sync, tag and check word
// - Full bit sets full status; cleared when page address is sent
// - Transfer starts only with proceed latched and begin strobe
// - In half-banks mode odd bit picks odd or even pages
// - Page bits select a data page; header bits locate header block
// - Latched write bit picks disk write, else disk read
// - Clear-end-page strobe clears end-of-page; completion sets it
// - Eight bus lines reach drives, qualified by a tag line
// - Control accepted only while the connect code is held
module ddc_channel_ctrl
   import ddc_pkg::*;
#(
   parameter logic [2:0] CONNECT_CODE = 3'h5,   // Arbitrary value
   parameter int         PAGE_WORDS   = `DDC_PAGE_WORDS,
   parameter int         HDR_WORDS    = `DDC_HDR_WORDS
) (
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic [15:0] cmdAddrWord,
   input  wire logic [15:0] strobeConnWord,
   input  wire logic [1:0]  bankSwitch,
   input  wire logic [8:0]  unitSelectedIn,
   input  wire logic [8:0]  onSectorIn,
   input  wire logic        busyIn,
   input  wire logic        readyIn,
   input  wire logic        seekErrIn,
   input  wire logic        onCylIn,
   input  wire logic        packUnsafeIn,
   input  wire logic        diskWordValid,
   input  wire logic [15:0] diskWord,
   input  wire logic [15:0] memTagWord,
   input  wire logic        memParityErr,
   input  wire logic [2:0]  memBank,
   output logic [15:0]      ifStatusWord,
   output logic [15:0]      driveStatusWord,
   output logic [7:0]       busLines,
   output logic             sectorSelTag,
   output logic             diffSelTag,
   output logic             ctrlSelTag,
   output logic             releaseLine,
   output logic             clearLine,
   output logic             unitSelLine,
   output logic [2:0]       logicNum,
   output logic [15:0]      memAddr,
   output logic             memAddrValid,
   output logic             xferActive,
   output logic             writeMode,
   output logic             writeTagsEn
);
   // Word counter is twelve bits wide; refuse sizes it cannot count
   if (PAGE_WORDS < 2 || PAGE_WORDS > `DDC_CNT_LIMIT
       || HDR_WORDS < 1 || HDR_WORDS > `DDC_CNT_LIMIT) begin : g_size_chk
      $error("ddc_channel_ctrl: page or header size out of range");
   end

   // ----------------------------------------------------------------------
   // Synchronisers and strobe edges
   // ----------------------------------------------------------------------
   logic [15:0] caW;
   logic [15:0] scW;
   logic [1:0]  bankSw;
   logic [22:0] drvSync;
   logic [15:0] scPrev_r;
   logic        connected;
   logic        beginPulse;
   logic        loadPulse;
   logic        clrEopPulse;

   ddc_sync #(.W(16)) u_syncCa (
      .clock (clock),
      .rstn  (rstn),
      .din   (cmdAddrWord),
      .dout  (caW)
   );
   ddc_sync #(.W(16)) u_syncSc (
      .clock (clock),
      .rstn  (rstn),
      .din   (strobeConnWord),
      .dout  (scW)
   );
   ddc_sync #(.W(25)) u_syncDrv (
      .clock (clock),
      .rstn  (rstn),
      .din   ({bankSwitch, unitSelectedIn, onSectorIn, busyIn, readyIn,
               seekErrIn, onCylIn, packUnsafeIn}),
      .dout  ({bankSw, drvSync})
   );

   // Previous strobe word for rising-edge detection
   always_ff @(posedge clock) begin
      if (!rstn) begin
         scPrev_r <= '0;
      end else begin
         scPrev_r <= scW;
      end
   end

   // Connect code gates every strobe and command
   assign connected = (scW[`DDC_SC_CONN_HI:0] == CONNECT_CODE);
   assign beginPulse = connected & scW[`DDC_SC_BEGIN]
                       & ~scPrev_r[`DDC_SC_BEGIN];
   assign loadPulse = connected & scW[`DDC_SC_LOADADR]
                      & ~scPrev_r[`DDC_SC_LOADADR];
   assign clrEopPulse = connected & scW[`DDC_SC_CLREOP]
                        & ~scPrev_r[`DDC_SC_CLREOP];

   // ----------------------------------------------------------------------
   // Drive command path
   // ----------------------------------------------------------------------
   logic funcOn;
   assign funcOn = connected & scW[`DDC_SC_FUNC];

   // Command meanings reach the drives only while function is held
   always_ff @(posedge clock) begin
      if (!rstn) begin
         busLines     <= '0;
         sectorSelTag <= 1'b0;
         diffSelTag   <= 1'b0;
         ctrlSelTag   <= 1'b0;
         releaseLine  <= 1'b0;
         clearLine    <= 1'b0;
         unitSelLine  <= 1'b0;
         logicNum     <= '0;
      end else begin
         busLines     <= funcOn ? caW[`DDC_CA_BUS_HI:0] : '0;
         sectorSelTag <= funcOn & caW[`DDC_CA_SECTOR];
         diffSelTag   <= funcOn & caW[`DDC_CA_DIFF];
         ctrlSelTag   <= funcOn & scW[`DDC_SC_CTRLSEL];
         releaseLine  <= funcOn & caW[`DDC_CA_RELEASE];
         clearLine    <= funcOn & caW[`DDC_CA_CLEAR];
         unitSelLine  <= funcOn & caW[`DDC_CA_UNIT];
         logicNum     <= funcOn ? caW[`DDC_CA_LOGIC_HI:`DDC_CA_LOGIC_LO]
                                : '0;
      end
   end

   // ----------------------------------------------------------------------
   // Address register, loaded only by the load-address strobe
   // ----------------------------------------------------------------------
   logic       wrTags_r;
   logic       fullBit_r;
   logic       proceed_r;
   logic       odd_r;
   logic       write_r;
   logic [3:0] page_r;
   logic [5:0] hdr_r;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         wrTags_r  <= 1'b0;
         fullBit_r <= 1'b0;
         proceed_r <= 1'b0;
         odd_r     <= 1'b0;
         write_r   <= 1'b0;
         page_r    <= '0;
         hdr_r     <= '0;
      end else if (loadPulse) begin
         wrTags_r  <= caW[`DDC_CA_RELEASE];
         fullBit_r <= caW[`DDC_CA_SECTOR];
         proceed_r <= caW[`DDC_CA_DIFF];
         odd_r     <= caW[`DDC_CA_CLEAR];
         write_r   <= caW[`DDC_CA_WRITE];
         page_r    <= caW[`DDC_CA_PAGE_HI:`DDC_CA_PAGE_LO];
         hdr_r     <= caW[`DDC_CA_HDR_HI:0];
      end
   end

   // Page and header addresses by bank mode
   logic        halfBanks;
   logic [3:0]  pageSel;
   logic [15:0] pageAddr;
   logic [15:0] hdrAddr;
   assign halfBanks = (bankSw != BM_FULL);
   assign pageSel = halfBanks ? {page_r[3:1], odd_r} : page_r;
   assign pageAddr = {1'b0, pageSel, 11'h000};
   assign hdrAddr = halfBanks ? {5'h00, hdr_r[4:0], 6'h00}
                              : {5'h00, hdr_r, 5'h00};

   // ----------------------------------------------------------------------
   // Transfer sequencer
   // ----------------------------------------------------------------------
   ddc_xfer_t   state_r;
   logic [11:0] wordCnt_r;
   logic        crcInit;
   logic        crcEn;
   logic [15:0] crcVal;
   logic        tagErrEv;
   logic        tagCmpEv;
   logic        bccErrEv;
   logic        pageDone;
   logic        startEv;

   assign startEv = beginPulse & proceed_r & (state_r == XS_IDLE);
   assign crcInit = startEv | (state_r == XS_HDR);
   assign crcEn = diskWordValid & ((state_r == XS_TAGW)
                  | (state_r == XS_PAGE & ~write_r));
   assign tagErrEv = (state_r == XS_TAGC) & diskWordValid & ~wrTags_r
                     & (diskWord != crcVal);
   assign tagCmpEv = (state_r == XS_TAGW) & diskWordValid & ~wrTags_r
                     & (diskWord != memTagWord);
   assign bccErrEv = (state_r == XS_BCC) & diskWordValid
                     & (diskWord != crcVal);
   assign pageDone = ((state_r == XS_PAGE) & write_r & diskWordValid
                      & (wordCnt_r == 12'(PAGE_WORDS - 1)))
                     | ((state_r == XS_BCC) & diskWordValid);

   ddc_crc u_crc (
      .clock (clock),
      .rstn  (rstn),
      .init  (crcInit),
      .en    (crcEn),
      .data  (diskWord),
      .crc   (crcVal)
   );

   // State and word counting
   always_ff @(posedge clock) begin
      if (!rstn) begin
         state_r   <= XS_IDLE;
         wordCnt_r <= '0;
      end else begin
         case (state_r)
            XS_IDLE: begin
               wordCnt_r <= '0;
               if (startEv) begin
                  state_r <= XS_TAGW;
               end
            end
            XS_TAGW: begin
               if (diskWordValid) begin
                  state_r <= XS_TAGC;
               end
            end
            XS_TAGC: begin
               if (diskWordValid) begin
                  state_r <= XS_HDR;
               end
            end
            XS_HDR: begin
               if (diskWordValid) begin
                  wordCnt_r <= wordCnt_r + 12'h001;
                  if (wordCnt_r == 12'(HDR_WORDS - 1)) begin
                     wordCnt_r <= '0;
                     state_r   <= XS_PAGE;
                  end
               end
            end
            XS_PAGE: begin
               if (diskWordValid) begin
                  wordCnt_r <= wordCnt_r + 12'h001;
                  if (wordCnt_r == 12'(PAGE_WORDS - 1)) begin
                     state_r <= write_r ? XS_IDLE : XS_BCC;
                  end
               end
            end
            XS_BCC: begin
               if (diskWordValid) begin
                  state_r <= XS_IDLE;
               end
            end
            default: state_r <= XS_IDLE;
         endcase
      end
   end

   // Page address to buffer_memory once the header has passed
   always_ff @(posedge clock) begin
      if (!rstn) begin
         memAddr      <= '0;
         memAddrValid <= 1'b0;
      end else begin
         memAddrValid <= (state_r == XS_HDR) & diskWordValid
                         & (wordCnt_r == 12'(HDR_WORDS - 1));
         memAddr      <= (state_r == XS_IDLE) ? hdrAddr : pageAddr;
      end
   end

   // ----------------------------------------------------------------------
   // Interface status flags; a set always wins over a clear
   // ----------------------------------------------------------------------
   logic       full_r;
   logic       eop_r;
   logic       rdErr_r;
   logic       tagErr_r;
   logic       xferErr_r;
   logic       notFin_r;
   logic [2:0] bankCnt_r;
   logic       rdErrEv;

   assign rdErrEv = xferActive & memParityErr | bccErrEv;

   always_ff @(posedge clock) begin
      if (!rstn) begin
         full_r <= 1'b0;
      end else if (loadPulse) begin
         full_r <= caW[`DDC_CA_SECTOR];
      end else if (memAddrValid) begin
         full_r <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         eop_r <= 1'b0;
      end else if (pageDone) begin
         eop_r <= 1'b1;
      end else if (clrEopPulse) begin
         eop_r <= 1'b0;
      end
   end

   // Error flags are cleared when a new transfer starts
   always_ff @(posedge clock) begin
      if (!rstn) begin
         rdErr_r   <= 1'b0;
         tagErr_r  <= 1'b0;
         xferErr_r <= 1'b0;
         bankCnt_r <= '0;
      end else begin
         if (rdErrEv) begin
            rdErr_r   <= 1'b1;
            bankCnt_r <= ~memBank;
         end else if (startEv) begin
            rdErr_r <= 1'b0;
         end
         if (tagErrEv) begin
            tagErr_r <= 1'b1;
         end else if (startEv) begin
            tagErr_r <= 1'b0;
         end
         if (rdErrEv | tagErrEv | tagCmpEv) begin
            xferErr_r <= 1'b1;
         end else if (startEv) begin
            xferErr_r <= 1'b0;
         end
      end
   end

   // Not-finished follows the sequencer
   always_ff @(posedge clock) begin
      if (!rstn) begin
         notFin_r    <= 1'b0;
         xferActive  <= 1'b0;
         writeMode   <= 1'b0;
         writeTagsEn <= 1'b0;
      end else begin
         notFin_r    <= startEv | (notFin_r & ~pageDone);
         xferActive  <= startEv | (xferActive & ~pageDone);
         writeMode   <= write_r;
         writeTagsEn <= wrTags_r & write_r;
      end
   end

   // ----------------------------------------------------------------------
   // Status words
   // ----------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rstn) begin
         ifStatusWord    <= `DDC_WORD_ZERO;
         driveStatusWord <= `DDC_WORD_ZERO;
      end else begin
         ifStatusWord <= {drvSync[22:14], full_r, rdErr_r, tagErr_r,
                          eop_r, bankCnt_r};
         driveStatusWord <= {drvSync[13:5], drvSync[4:0], xferErr_r,
                             notFin_r};
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   a_start_needs_proceed: assert property (
      $rose(notFin_r) |-> $past(proceed_r) && $past(beginPulse))
      else $error("transfer started without proceed and begin");
   a_tag_error_flags: assert property (
      tagErrEv |=> tagErr_r && xferErr_r)
      else $error("tag check error not flagged");
   a_xfer_error_cause: assert property (
      $rose(xferErr_r) |-> $past(rdErrEv || tagErrEv || tagCmpEv))
      else $error("transfer error without cause");
   a_eop_on_done: assert property (
      pageDone |=> eop_r ##1 ifStatusWord[`DDC_IS_EOP])
      else $error("end of page not raised");
   a_eop_clear: assert property (
      clrEopPulse && !pageDone |=> !eop_r)
      else $error("end of page not cleared");
   a_bank_complement: assert property (
      rdErrEv |=> bankCnt_r == ~$past(memBank))
      else $error("bank count not complemented");
   a_notfin_busy: assert property (
      (state_r != XS_IDLE) |-> notFin_r)
      else $error("finished bit dropped during transfer");
   a_func_gates: assert property (
      !funcOn |=> busLines == 8'h00 && !sectorSelTag && !diffSelTag)
      else $error("drive command passed without function");
   a_full_drop: assert property (
      memAddrValid && !loadPulse |=> !full_r)
      else $error("full not cleared on page address");
   a_addr_hold: assert property (
      !loadPulse |=> $stable(page_r) && $stable(hdr_r) && $stable(write_r))
      else $error("address field changed without load");

   c_write_page: cover property (startEv && write_r ##[1:300] pageDone);
   c_read_page: cover property (startEv && !write_r);
   c_tag_err: cover property (tagErrEv);
   c_half_odd: cover property (startEv && halfBanks && odd_r);
endmodule

// ---- test/ddc_drive_model.sv ----
// Purpose: Drive-side model for the channel control bench
// Assumes: One reserve state stands for every unit
// Notes:   Up to eight disk words, every other cycle, while go is high
`timescale 1ns/1ps
module ddc_drive_model (
   input  wire logic       clock,
   input  wire logic       go,
   input  wire logic [4:0] cond,
   input  wire logic       unitSelLine,
   input  wire logic       releaseLine,
   input  wire logic       clearLine,
   output logic [8:0]      unitSelectedIn,
   output logic [8:0]      onSectorIn,
   output logic [4:0]      stat,
   output logic            diskWordValid = 1'b0,
   output logic [15:0]     diskWord = 16'h0000
);
   logic       rsv = 1'b0;
   logic [3:0] n = 4'h0;
   logic       send;
   // ----
   // Reserve, status and disk words
   // ----
   always @(posedge clock) begin
      if (releaseLine | clearLine) rsv <= 1'b0;
      else if (unitSelLine) rsv <= 1'b1;
   end
   assign unitSelectedIn = {9{rsv}};
   assign onSectorIn = {9{cond[1]}};   // Copy of on cylinder
   assign stat = cond;
   assign send = go && !diskWordValid && n < 4'h8;
   // Released data lines toggle each cycle between the last word and its inverse
   always @(posedge clock) begin
      diskWordValid <= send;
      diskWord <= send ? 16'ha5a0 + {12'h000, n} : ~diskWord;
      if (send) n <= n + 4'h1;
   end
endmodule

// ---- test/ddc_channel_ctrl_bench.sv ----
// Purpose: Self-checking bench for the channel control
// Assumes: Shortened page and header counts
// Notes:   Expected values queue up for a watcher process
`timescale 1ns/1ps
module ddc_channel_ctrl_bench;
   import ddc_pkg::*;
   logic        clock = 1'b0, rstn = 1'b0, go = 1'b0;
   logic [15:0] cmdAddrWord = 16'h0000, strobeConnWord = 16'h0000;
   logic [15:0] ifStatusWord, driveStatusWord, diskWord, c, e;
   logic [4:0]  cond = 5'h00, st;
   logic [8:0]  unitSelectedIn, onSectorIn;
   logic [7:0]  busLines;
   logic        diskWordValid, sectorSelTag, diffSelTag, ctrlSelTag;
   logic        releaseLine, clearLine, unitSelLine, xferActive;
   logic        writeMode, writeTagsEn, memAddrValid, perr = 1'b0;
   logic [2:0]  logicNum, mb = 3'h0;
   logic [1:0]  bank = 2'h0;
   logic [15:0] memAddr;
   logic [33:0] q[$];
   int          fails = 0, compares = 0;
   event        seen;
   always #12.5 clock = ~clock;
   ddc_channel_ctrl #(.PAGE_WORDS(4), .HDR_WORDS(2)) dut_u (
      .clock, .rstn, .cmdAddrWord, .strobeConnWord, .bankSwitch(bank),
      .unitSelectedIn, .onSectorIn, .busyIn(st[4]), .readyIn(st[3]),
      .seekErrIn(st[2]), .onCylIn(st[1]), .packUnsafeIn(st[0]),
      .diskWordValid, .diskWord, .memTagWord(16'h0000),
      .memParityErr(perr), .memBank(mb), .ifStatusWord,
      .driveStatusWord, .busLines, .sectorSelTag, .diffSelTag,
      .ctrlSelTag, .releaseLine, .clearLine, .unitSelLine,
      .logicNum, .memAddr, .memAddrValid, .xferActive,
      .writeMode, .writeTagsEn);
   ddc_drive_model drv_u (.clock, .go, .cond, .unitSelLine, .releaseLine,
      .clearLine, .unitSelectedIn, .onSectorIn, .stat(st), .diskWordValid,
      .diskWord);
   // ----
   // Shared tasks
   // ----
   task note(input [1:0] s, input [15:0] m, input [15:0] x);
      q.push_back({s, m, x});
      -> seen;
      #1;
   endtask
   task tick(input int n);
      repeat (n) @(negedge clock);
   endtask
   task strobe(input [15:0] s);
      strobeConnWord = s | 16'h0005;
      tick(3);
      strobeConnWord = 16'h0005;
      tick(3);
   endtask
   task give_verdict;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Watcher takes the oldest note and compares the selected output
   always @(seen) begin : watch
      logic [33:0] t;
      logic [15:0] a;
      t = q.pop_front();
      a = t[33:32] == 2'h0 ? {xferActive, writeMode, releaseLine,
          sectorSelTag, diffSelTag, clearLine, unitSelLine, ctrlSelTag,
          busLines} : t[33:32] == 2'h1 ? ifStatusWord : t[33:32] == 2'h2
          ? driveStatusWord : {logicNum, writeTagsEn, memAddrValid,
          memAddr[15:5]};
      compares++;
      if ((a & t[31:16]) !== t[15:0]) begin
         fails++;
         $display("BAD %0t exp %h got %h", $time, t[15:0], a & t[31:16]);
      end
   end
   // Watchdog well past the hundred-odd cycles of the tests
   initial begin
      #1000000;
      fails++;
      give_verdict;
   end
   // ----
   // Tests
   // ----
   initial begin
      c = $urandom(32'h993d);
      tick(4);
      rstn = 1'b1;
      tick(2);
      strobe(16'h0080);
      note(0, 16'hc000, 16'h0000);
      for (int i = 0; i < 6; i++) begin
         c = $urandom;
         if (c[14]) c[7:0] = {5'h00, {3{c[0]}}};
         cmdAddrWord = c;
         strobeConnWord = i < 4 ? 16'h001d : i == 4 ? 16'h001c : 16'h0015;
         e = i < 4 ? {2'h0, c[15:12], c[8], 1'b1, c[7:0]} : 16'h0000;
         tick(4);
         note(0, 16'h3fff, e);
         note(3, 16'he000, i < 4 ? {c[11:9], 13'h0000} : 16'h0000);
      end
      cmdAddrWord = 16'h0100;
      strobeConnWord = 16'h000d;
      tick(8);
      note(1, 16'hff80, 16'hff80);
      cmdAddrWord = 16'h1000;
      tick(8);
      note(1, 16'hff80, 16'h0000);
      strobeConnWord = 16'h0005;
      $display("command test done");
      for (int i = 0; i < 3; i++) begin
         cond = 5'($urandom);
         tick(6);
         note(2, 16'hfffc, {{9{cond[1]}}, cond, 2'h0});
      end
      $display("status test done");
      bank = 2'h2;
      cmdAddrWord = 16'h7080 | (c & 16'h0f3f);
      tick(2);
      strobe(16'h0020);
      cmdAddrWord = 16'h0000;
      tick(2);
      note(1, 16'h0040, 16'h0040);
      note(0, 16'h4000, 16'h4000);
      note(3, 16'hffff, {10'h000, c[4:0], 1'b0});
      strobe(16'h0040);
      strobe(16'h0080);
      note(2, 16'h0001, 16'h0001);
      note(0, 16'h8000, 16'h8000);
      note(3, 16'hffff, {6'h00, c[11:9], 1'b1, 6'h00});
      mb = 3'($urandom);
      perr = 1'b1;
      tick(1);
      perr = 1'b0;
      go = 1'b1;
      for (int k = 0; k < 60 && ifStatusWord[3] !== 1'b1; k++) tick(1);
      tick(2);
      note(1, 16'h0048, 16'h0008);
      note(1, 16'h0027, {10'h000, 1'b1, 2'h0, ~mb});
      note(2, 16'h0003, 16'h0002);
      go = 1'b0;
      strobe(16'h0040);
      note(1, 16'h0008, 16'h0000);
      $display("transfer test done");
      tick(2);
      give_verdict;
   end
endmodule
